// >>> hdl/zp_link_pkg.sv
// package: register map, field codes and timing for the zero-point and serial-link register bank
package zp_link_pkg;
  // register word addresses (holding register numbers)
  localparam logic [15:0] ADDR_FLOAT_ORDER = 16'h020F;
  localparam logic [15:0] ADDR_NODE = 16'h0210;
  localparam logic [15:0] ADDR_RATE = 16'h0211;
  localparam logic [15:0] ADDR_PARITY = 16'h0212;
  localparam logic [15:0] ADDR_RESTART = 16'h0258;
  localparam logic [15:0] ADDR_METHOD = 16'h0854;
  localparam logic [15:0] ADDR_MAN_OFS = 16'h0855;
  localparam logic [15:0] ADDR_DURATION = 16'h0857;
  localparam logic [15:0] ADDR_SIGMA = 16'h0858;
  localparam logic [15:0] ADDR_SIGMA_LIM = 16'h085A;
  localparam logic [15:0] ADDR_OFS_LIM = 16'h085C;
  localparam logic [15:0] ADDR_FACT_OFS = 16'h085E;
  localparam logic [15:0] ADDR_PROGRESS = 16'h0860;
  localparam logic [15:0] ADDR_ERR = 16'h0861;
  localparam logic [15:0] ADDR_START = 16'h0884;
  // reset values
  localparam logic [1:0] RST_FLOAT_ORDER = 2'h3;
  localparam logic [7:0] RST_NODE = 8'h01;
  localparam logic [2:0] RST_RATE = 3'h1;
  localparam logic [1:0] RST_PARITY = 2'h0;
  localparam logic [9:0] RST_DURATION = 10'h01E;
  localparam logic [31:0] RST_SIGMA_LIM = 32'h0000_0000;
  localparam logic [31:0] RST_OFS_LIM = 32'h0000_0000;
  localparam logic [31:0] RST_FACT_OFS = 32'h0000_0000;
  // legal ranges
  localparam logic [15:0] DURATION_MIN = 16'h0001;
  localparam logic [15:0] DURATION_MAX = 16'h03E7;
  localparam logic [15:0] NODE_MIN = 16'h0001;
  localparam logic [15:0] NODE_MAX = 16'h00F7;
  localparam logic [15:0] RATE_MAX = 16'h0005;
  localparam logic [15:0] PARITY_MAX = 16'h0002;
  localparam logic [15:0] ORDER_MAX = 16'h0003;
  localparam logic [15:0] METHOD_MAX = 16'h0001;
  // command and status codes
  localparam logic [15:0] START_CODE = 16'h0002;
  localparam logic [15:0] RUNNING_CODE = 16'h0001;
  localparam logic [15:0] RESTART_CODE = 16'h0001;
  localparam logic [6:0] PROGRESS_FULL = 7'h64;
  localparam int ERR_SIGMA_BIT = 1;
  localparam int ERR_OFS_BIT = 2;
  localparam int ERR_QUALITY_BIT = 4;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int SECOND_CYCLES = CLK_HZ;
  localparam int BAUD_9600 = 9600;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_38400 = 38400;
  localparam int BAUD_57600 = 57600;
  localparam int BAUD_76800 = 76800;
  localparam int BAUD_115200 = 115200;
  localparam int DATA_BITS = 8;

  typedef enum logic [1:0] {
    ZP_IDLE = 2'b00,
    ZP_RUN = 2'b01,
    ZP_EVAL = 2'b11
  } zp_state_e;

  // register access request from the frame handler
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  // serial line settings applied to the frame handler
  typedef struct packed {
    logic [7:0] node;
    logic [15:0] bit_div;
    logic parity_en;
    logic parity_odd;
    logic two_stop;
    logic [1:0] float_order;
  } link_cfg_s;

  // one measurement sample from the flow path
  typedef struct packed {
    logic valid;
    logic [31:0] sigma;
    logic [31:0] offset;
    logic quality_poor;
  } zp_meas_s;
endpackage

// >>> hdl/float_order_mux.sv
// float_order_mux: places a big-endian float into line send order
`timescale 1ns/100ps
module float_order_mux (
  // selection
  input wire logic [1:0] order,
  // value and line-ordered bytes, first byte sent in bits 31:24
  input wire logic [31:0] value,
  output logic [31:0] line_bytes
);
  logic [7:0] b3, b2, b1, b0;
  assign b3 = value[31:24];
  assign b2 = value[23:16];
  assign b1 = value[15:8];
  assign b0 = value[7:0];
  always_comb begin
    unique case (order)
      2'h0: line_bytes = {b1, b0, b3, b2};
      2'h1: line_bytes = {b0, b1, b2, b3};
      2'h2: line_bytes = {b2, b3, b0, b1};
      2'h3: line_bytes = {b3, b2, b1, b0};
    endcase
  end
endmodule

// >>> hdl/zp_link_regs.sv
// zp_link_regs: zero-point adjustment and serial-link holding registers
//
// Overview of operation
// - method 0 is automatic and 1 is manual, and manual mode applies the written manual offset.
// - an adjustment lasts the duration register in seconds, reset 30, writes 1 to 999 accepted.
// - during an automatic adjustment the measured standard deviation is shown read-only.
// - the automatic adjustment aborts when the deviation exceeds the deviation limit.
// - a new offset above the offset limit is not stored.
// - the factory default offset is shown read-only and resets to zero.
// - progress reads 0 to 100 percent while an adjustment runs.
// - error bits 1, 2 and 4 flag sigma, offset and quality faults, all zero meaning success.
// - writing 2 to start launches an automatic adjustment, reading 1 while running, 0 idle.
// - floats go out in order 1-0-3-2, 0-1-2-3, 2-3-0-1 or 3-2-1-0 for codes 0 to 3, reset 3.
// - byte 3 is the float's MSB, byte 0 its LSB, and the first listed byte is sent first.
// - baud codes 0 to 5 select 9600, 19200, 38400, 57600, 76800, 115200, reset 19200.
// - every character carries eight data bits.
// - parity code 0 is even with 1 stop, 1 odd with 1 stop, 2 none with 2 stops, reset 0.
`timescale 1ns/100ps
module zp_link_regs
  import zp_link_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access from the frame handler
  input wire zp_link_pkg::reg_req_s req,
  output logic [15:0] rdata,
  output logic rvalid,
  // address match for an incoming frame
  input wire logic [7:0] frame_addr,
  output logic frame_for_us,
  // measurement samples during an adjustment and the factory offset
  input wire zp_link_pkg::zp_meas_s meas,
  input wire logic [31:0] fact_offset,
  // link settings and restart
  output zp_link_pkg::link_cfg_s link_cfg,
  output logic link_restart,
  // float serialisation
  input wire logic [31:0] float_in,
  output logic [31:0] float_line,
  // applied zero offset and adjustment busy
  output logic [31:0] zero_offset,
  output logic zp_busy
);
  import zp_link_pkg::*;

  typedef struct packed {
    logic [1:0] order;
    logic [7:0] node;
    logic [2:0] rate;
    logic [1:0] parity;
    logic method;
    logic [31:0] man_ofs;
    logic [9:0] duration;
    logic [31:0] sigma;
    logic [31:0] sigma_lim;
    logic [31:0] ofs_lim;
    logic [31:0] fact_ofs;
    logic [31:0] auto_ofs;
    logic [6:0] progress;
    logic [4:0] err;
    zp_state_e state;
    logic [24:0] sec_cnt;
    logic [9:0] secs;
    logic quality_poor;
    logic [31:0] cand_ofs;
    logic cand_valid;
    logic [15:0] rdata;
    logic rvalid;
    logic restart;
    link_cfg_s cfg;
  } state_s;

  state_s cur, nxt;

  localparam logic [24:0] SEC_LAST = 25'(SECOND_CYCLES - 1);

  function automatic logic [15:0] rate_div(input logic [2:0] code);
    int hz;
    unique case (code)
      3'h0: hz = BAUD_9600;
      3'h1: hz = BAUD_19200;
      3'h2: hz = BAUD_38400;
      3'h3: hz = BAUD_57600;
      3'h4: hz = BAUD_76800;
      default: hz = BAUD_115200;
    endcase
    return 16'(CLK_HZ / hz);
  endfunction

  function automatic logic [6:0] pct(input logic [9:0] done, input logic [9:0] total);
    logic [16:0] p;
    p = 17'(done) * 17'(PROGRESS_FULL) / 17'(total);
    return (p > 17'(PROGRESS_FULL)) ? PROGRESS_FULL : p[6:0];
  endfunction

  // ordered compare of two single-precision floats, minus zero equal to plus zero;
  // a plain unsigned compare would rank every negative value above any positive one
  function automatic logic float_gt(input logic [31:0] a, input logic [31:0] b);
    logic gt;
    if (a[30:0] == 31'h00000000 && b[30:0] == 31'h00000000) gt = 1'b0;
    else if (a[31] != b[31]) gt = b[31];
    else if (!a[31]) gt = (a[30:0] > b[30:0]);
    else gt = (a[30:0] < b[30:0]);
    return gt;
  endfunction

  always_comb begin
    logic [15:0] rd;
    logic start_req;
    nxt = cur;
    rd = 16'h0000;
    nxt.rvalid = req.rd;
    nxt.restart = 1'b0;
    nxt.fact_ofs = fact_offset;
    start_req = 1'b0;
    if (req.wr) begin
      unique case (req.addr)
        ADDR_FLOAT_ORDER: if (req.wdata <= ORDER_MAX) nxt.order = req.wdata[1:0];
        ADDR_NODE:
          if (req.wdata >= NODE_MIN && req.wdata <= NODE_MAX) nxt.node = req.wdata[7:0];
        ADDR_RATE: if (req.wdata <= RATE_MAX) nxt.rate = req.wdata[2:0];
        ADDR_PARITY: if (req.wdata <= PARITY_MAX) nxt.parity = req.wdata[1:0];
        ADDR_RESTART: nxt.restart = (req.wdata == RESTART_CODE);
        ADDR_METHOD: if (req.wdata <= METHOD_MAX) nxt.method = req.wdata[0];
        ADDR_MAN_OFS: nxt.man_ofs[31:16] = req.wdata;
        ADDR_MAN_OFS + 16'h0001: nxt.man_ofs[15:0] = req.wdata;
        ADDR_DURATION:
          if (req.wdata >= DURATION_MIN && req.wdata <= DURATION_MAX) begin
            nxt.duration = req.wdata[9:0];
          end
        ADDR_SIGMA_LIM: nxt.sigma_lim[31:16] = req.wdata;
        ADDR_SIGMA_LIM + 16'h0001: nxt.sigma_lim[15:0] = req.wdata;
        ADDR_OFS_LIM: nxt.ofs_lim[31:16] = req.wdata;
        ADDR_OFS_LIM + 16'h0001: nxt.ofs_lim[15:0] = req.wdata;
        ADDR_START: start_req = (req.wdata == START_CODE);
        default: ;
      endcase
    end
    // restart applies all settings at once
    if (cur.restart) begin
      nxt.cfg.node = cur.node;
      nxt.cfg.bit_div = rate_div(cur.rate);
      nxt.cfg.parity_en = (cur.parity != 2'h2);
      nxt.cfg.parity_odd = (cur.parity == 2'h1);
      nxt.cfg.two_stop = (cur.parity == 2'h2);
      nxt.cfg.float_order = cur.order;
    end
    unique case (cur.state)
      ZP_IDLE: begin
        if (start_req) begin
          nxt.state = ZP_RUN;
          nxt.sec_cnt = '0;
          nxt.secs = '0;
          nxt.progress = '0;
          nxt.err = '0;
          nxt.sigma = '0;
          nxt.quality_poor = 1'b0;
          nxt.cand_valid = 1'b0;
        end
      end
      ZP_RUN: begin
        if (meas.valid) begin
          nxt.sigma = meas.sigma;
          nxt.cand_ofs = meas.offset;
          nxt.cand_valid = 1'b1;
          nxt.quality_poor = cur.quality_poor | meas.quality_poor;
          if (float_gt(meas.sigma, cur.sigma_lim)) begin
            nxt.err[ERR_SIGMA_BIT] = 1'b1;
            nxt.state = ZP_IDLE;
          end
        end
        if (nxt.state == ZP_RUN) begin
          if (cur.sec_cnt == SEC_LAST) begin
            nxt.sec_cnt = '0;
            nxt.secs = cur.secs + 10'h001;
            nxt.progress = pct(cur.secs + 10'h001, cur.duration);
            if (cur.secs + 10'h001 >= cur.duration) nxt.state = ZP_EVAL;
          end else begin
            nxt.sec_cnt = cur.sec_cnt + 25'h0000001;
          end
        end
      end
      ZP_EVAL: begin
        nxt.state = ZP_IDLE;
        nxt.progress = PROGRESS_FULL;
        nxt.err[ERR_QUALITY_BIT] = cur.quality_poor | ~cur.cand_valid;
        if (cur.cand_valid && float_gt(cur.cand_ofs, cur.ofs_lim)) begin
          nxt.err[ERR_OFS_BIT] = 1'b1;
        end else if (cur.cand_valid && !cur.quality_poor) begin
          nxt.auto_ofs = cur.cand_ofs;
        end
      end
      default: nxt.state = ZP_IDLE;
    endcase
    if (req.rd) begin
      unique case (req.addr)
        ADDR_FLOAT_ORDER: rd = {14'h0000, cur.order};
        ADDR_NODE: rd = {8'h00, cur.node};
        ADDR_RATE: rd = {13'h0000, cur.rate};
        ADDR_PARITY: rd = {14'h0000, cur.parity};
        ADDR_METHOD: rd = {15'h0000, cur.method};
        ADDR_MAN_OFS: rd = cur.man_ofs[31:16];
        ADDR_MAN_OFS + 16'h0001: rd = cur.man_ofs[15:0];
        ADDR_DURATION: rd = {6'h00, cur.duration};
        ADDR_SIGMA: rd = cur.sigma[31:16];
        ADDR_SIGMA + 16'h0001: rd = cur.sigma[15:0];
        ADDR_SIGMA_LIM: rd = cur.sigma_lim[31:16];
        ADDR_SIGMA_LIM + 16'h0001: rd = cur.sigma_lim[15:0];
        ADDR_OFS_LIM: rd = cur.ofs_lim[31:16];
        ADDR_OFS_LIM + 16'h0001: rd = cur.ofs_lim[15:0];
        ADDR_FACT_OFS: rd = cur.fact_ofs[31:16];
        ADDR_FACT_OFS + 16'h0001: rd = cur.fact_ofs[15:0];
        ADDR_PROGRESS: rd = {9'h000, cur.progress};
        ADDR_ERR: rd = {11'h000, cur.err};
        ADDR_START: rd = (cur.state != ZP_IDLE) ? RUNNING_CODE : 16'h0000;
        default: rd = 16'h0000; // restart reads zero too
      endcase
    end
    nxt.rdata = rd;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.order <= RST_FLOAT_ORDER;
      cur.node <= RST_NODE;
      cur.rate <= RST_RATE;
      cur.parity <= RST_PARITY;
      cur.duration <= RST_DURATION;
      cur.sigma_lim <= RST_SIGMA_LIM;
      cur.ofs_lim <= RST_OFS_LIM;
      cur.fact_ofs <= RST_FACT_OFS;
      cur.state <= ZP_IDLE;
      cur.cfg.node <= RST_NODE;
      cur.cfg.bit_div <= 16'(CLK_HZ / BAUD_19200);
      cur.cfg.parity_en <= 1'b1;
      cur.cfg.parity_odd <= 1'b0;
      cur.cfg.two_stop <= 1'b0;
      cur.cfg.float_order <= RST_FLOAT_ORDER;
    end else begin
      cur <= nxt;
    end
  end

  float_order_mux u_order (
    .order(cur.cfg.float_order),
    .value(float_in),
    .line_bytes(float_line)
  );

  assign rdata = cur.rdata;
  assign rvalid = cur.rvalid;
  assign link_cfg = cur.cfg; // eight data bits per character always
  assign link_restart = cur.restart;
  assign frame_for_us = (frame_addr == cur.cfg.node);
  assign zero_offset = cur.method ? cur.man_ofs : cur.auto_ofs;
  assign zp_busy = (cur.state != ZP_IDLE);
endmodule

// >>> testbench/zp_link_regs_properties.sv
// checker: port relations of the zero-point and link register bank
`timescale 1ns/100ps
module zp_link_regs_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register access
  input wire zp_link_pkg::reg_req_s req,
  input wire logic [15:0] rdata,
  // link side
  input wire logic [7:0] frame_addr,
  input wire logic frame_for_us,
  input wire zp_link_pkg::link_cfg_s link_cfg,
  input wire logic link_restart,
  input wire logic [31:0] float_in,
  input wire logic [31:0] float_line,
  input wire logic zp_busy
);
  import zp_link_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] line_exp;
  always_comb begin
    case (link_cfg.float_order)
      2'h0: line_exp = {float_in[15:0], float_in[31:16]};
      2'h1: line_exp = {float_in[7:0], float_in[15:8], float_in[23:16], float_in[31:24]};
      2'h2: line_exp = {float_in[23:16], float_in[31:24], float_in[7:0], float_in[15:8]};
      default: line_exp = float_in;
    endcase
  end
  a_float_line_order: assert property (float_line == line_exp)
    else $error("float line order wrong");
  a_restart_one_pulse: assert property (
    req.wr && req.addr == ADDR_RESTART && req.wdata == RESTART_CODE |=> link_restart)
    else $error("restart pulse missing");
  a_restart_zero_idle: assert property (
    req.wr && req.addr == ADDR_RESTART && req.wdata == 16'h0000 |=> !link_restart)
    else $error("restart on zero write");
  a_cfg_held_between: assert property (!link_restart |=> $stable(link_cfg))
    else $error("settings changed without restart");
  a_restart_reads_zero: assert property (
    req.rd && req.addr == ADDR_RESTART |=> rdata == 16'h0000)
    else $error("restart register read not zero");
  a_frame_addr_match: assert property (
    frame_for_us == (frame_addr == link_cfg.node))
    else $error("frame address match wrong");
  a_node_in_range: assert property (link_cfg.node inside {[8'h01:8'hF7]})
    else $error("applied node address out of range");
  a_framing_legal: assert property (link_cfg.parity_en != link_cfg.two_stop)
    else $error("parity and stop bits inconsistent");
  a_start_sets_busy: assert property (
    req.wr && req.addr == ADDR_START && req.wdata == START_CODE |=> zp_busy)
    else $error("start did not launch adjustment");
  a_start_read_state: assert property (
    req.rd && req.addr == ADDR_START |=> rdata == {15'h0000, $past(zp_busy)})
    else $error("start register readback wrong");
endmodule

// >>> testbench/reg_master.sv
// partner: frame handler side issuing register requests
`timescale 1ns/100ps
module reg_master (
  // clock
  input wire logic clk,
  // register access
  output zp_link_pkg::reg_req_s req,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  import zp_link_pkg::*;
  initial req = '0;
  // a 16-bit word is driven whole for one clock from a falling edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req = '0;
  endtask
  // answer stands from the taking edge and is read at the next falling edge
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, 16'h0000};
    @(negedge clk);
    req = '0;
    d = rvalid ? rdata : 16'hXXXX;
  endtask
endmodule

// >>> testbench/testbench.sv
// testbench: register bank compared against a behavioural model
`timescale 1ns/100ps
module testbench;
  import zp_link_pkg::*;
  logic clk, rst, frame_for_us, rvalid, link_restart, zp_busy;
  zp_link_pkg::reg_req_s req;
  zp_link_pkg::zp_meas_s meas;
  zp_link_pkg::link_cfg_s link_cfg;
  logic [7:0] frame_addr;
  logic [15:0] rdata, v;
  logic [31:0] fact_offset, float_in, float_line, zero_offset, f, e;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int pn = 1;
  int mdl[6] = '{3, 1, 1, 0, 0, 30};
  int lo[6] = '{0, 1, 0, 0, 0, 1};
  int hi[6] = '{3, 247, 5, 2, 1, 999};
  logic [15:0] ra[6] = '{ADDR_FLOAT_ORDER, ADDR_NODE, ADDR_RATE, ADDR_PARITY, ADDR_METHOD,
    ADDR_DURATION};
  int ord[4][4] = '{'{1, 0, 3, 2}, '{0, 1, 2, 3}, '{2, 3, 0, 1}, '{3, 2, 1, 0}};
  logic [2:0] par[3] = '{3'b100, 3'b110, 3'b001};
  int bd[6] = '{BAUD_9600, BAUD_19200, BAUD_38400, BAUD_57600, BAUD_76800, BAUD_115200};
  zp_link_regs dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .frame_addr(frame_addr), .frame_for_us(frame_for_us), .meas(meas),
    .fact_offset(fact_offset), .link_cfg(link_cfg), .link_restart(link_restart),
    .float_in(float_in), .float_line(float_line), .zero_offset(zero_offset),
    .zp_busy(zp_busy));
  reg_master host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    host.rd(a, v);
    check("register read", {16'h0000, v}, exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    rst = 1'b1;
    meas = '0;
    fact_offset = '0;
    float_in = '0;
    frame_addr = 8'h00;
    void'($urandom(96284));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    foreach (ra[i]) rchk(ra[i], mdl[i]);
    rchk(ADDR_FACT_OFS, 0);
    rchk(ADDR_PROGRESS, 0);
    rchk(ADDR_START, 0);
    check("divider", link_cfg.bit_div, 1041);
    for (int k = 0; k < 7; k++) begin
      foreach (ra[i]) begin
        v = (k == 0) ? 16'(hi[i] + 1) : 16'($urandom_range(hi[i] + 2));
        host.wr(ra[i], v);
        if (v >= lo[i] && v <= hi[i]) mdl[i] = v;
        rchk(ra[i], mdl[i]);
      end
    end
    f = $urandom;
    fact_offset = f;
    host.wr(ADDR_FACT_OFS, ~f[31:16]);
    rchk(ADDR_FACT_OFS, f[31:16]);
    rchk(ADDR_FACT_OFS + 16'h0001, f[15:0]);
    for (int k = 0; k < 4; k++) begin
      host.wr(ADDR_FLOAT_ORDER, 16'(k));
      host.wr(ADDR_PARITY, 16'(k % 3));
      host.wr(ADDR_NODE, 16'(k + 100));
      host.wr(ADDR_RATE, 16'(k + 2));
      mdl[2] = k + 2;
      host.wr(ADDR_RESTART, 16'h0000);
      frame_addr = 8'(pn);
      #1 check("node kept", frame_for_us, 1);
      host.wr(ADDR_RESTART, RESTART_CODE);
      repeat (2) @(negedge clk);
      pn = k + 100;
      float_in = $urandom;
      frame_addr = 8'(pn + 1);
      #1 check("node other", frame_for_us, 0);
      check("order", link_cfg.float_order, k);
      check("framing", {link_cfg.parity_en, link_cfg.parity_odd, link_cfg.two_stop},
        par[k % 3]);
      check("divider", link_cfg.bit_div, CLK_HZ / bd[k + 2]);
      for (int j = 0; j < 4; j++) e = {e[23:0], float_in[8 * ord[k][j] +: 8]};
      check("float line", float_line, e);
    end
    rchk(ADDR_RESTART, 0);
    host.wr(ADDR_SIGMA_LIM + 16'h0001, 16'h0100);
    host.wr(ADDR_START, START_CODE);
    rchk(ADDR_START, RUNNING_CODE);
    rchk(ADDR_PROGRESS, 0);
    host.wr(ADDR_START, START_CODE);
    meas = '{1'b1, 32'h0000_0080, 32'h0000_0000, 1'b0};
    @(negedge clk);
    meas.valid = 1'b0;
    rchk(ADDR_SIGMA + 16'h0001, 16'h0080);
    check("busy", zp_busy, 1);
    meas = '{1'b1, 32'hBF80_0000, 32'h0000_0000, 1'b0};
    @(negedge clk);
    meas.valid = 1'b0;
    rchk(ADDR_SIGMA, 16'hBF80);
    check("negative sigma", zp_busy, 1);
    meas = '{1'b1, 32'h0000_0101, 32'h0000_0000, 1'b0};
    @(negedge clk);
    meas.valid = 1'b0;
    repeat (2) @(negedge clk);
    check("abort", zp_busy, 0);
    rchk(ADDR_ERR, 16'h0002);
    rchk(ADDR_START, 0);
    host.wr(ADDR_METHOD, 16'h0001);
    host.wr(ADDR_MAN_OFS, f[31:16]);
    host.wr(ADDR_MAN_OFS + 16'h0001, f[15:0]);
    check("manual offset", zero_offset, f);
    host.wr(ADDR_START, RUNNING_CODE);
    @(negedge clk);
    check("start refused", zp_busy, 0);
    give_verdict();
  end
endmodule
bind zp_link_regs zp_link_regs_properties chk (.clk(clk), .rst(rst), .req(req),
  .rdata(rdata), .frame_addr(frame_addr), .frame_for_us(frame_for_us),
  .link_cfg(link_cfg), .link_restart(link_restart), .float_in(float_in),
  .float_line(float_line), .zp_busy(zp_busy));
